/* hw/link_status_pkg.sv */
// Constants for the unit link status word map
package link_status_pkg;
  localparam int          WORD_W         = 16;          // Status word width
  localparam int          ADR_W          = 8;           // Byte address width on the bus
  localparam int          SW_W           = 4;           // Address range switch width
  localparam int          BASE_W         = 4;           // Module base number width
  localparam int          UNIT_CNT       = 15;          // Units per address range
  localparam int          FIRST_ADDR_W   = 8;           // Width of switch times range
  localparam logic [5:0]  STW_OFFSET     = 6'h0b;       // Status word index = base + 11
  localparam logic [5:0]  STW_BASE_IDX   = 6'h02;       // Index of base link status word
  localparam logic [5:0]  INFO_IDX       = 6'h1c;       // Address range info word
  localparam logic [5:0]  IRQ_STAT_IDX   = 6'h1d;       // Sticky event status
  localparam logic [5:0]  IRQ_MASK_IDX   = 6'h1e;       // Event mask
  localparam int          BCAST_BITNUM   = 1;           // Broadcast channel bit number
  localparam int          IRQ_W          = 2;           // Number of event bits
  localparam int          IRQ_UNIT       = 0;           // Unit word changed
  localparam int          IRQ_BASE       = 1;           // Controller link changed
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 2'h0;     // Mask reset value

  // Bit number n (1 = most significant, 16 = least) to bit index
  function automatic int bit_idx(input int n);
    bit_idx = WORD_W - n;
  endfunction
endpackage

/* hw/unit_link_status_map.sv */
// Wishbone register bank mapping remote unit link state into status words
//
// Overview of operation
// (RULE_01) Unit link word sits at status word index equal to base number plus 11.
// (RULE_02) Bit number 16 is least significant, bit number 1 most significant.
// (RULE_03) Unit at switch times 15 plus k reports on bit number 17 minus k.
// (RULE_04) Broadcast-immediate channel status appears on bit number 1, the MSB.
// (RULE_05) Controller link status for base b is bit number 16 minus b of word 2.
// (RULE_06) A status bit reads one while communicating correctly, zero otherwise.
`timescale 1ns/1ps
module unit_link_status_map (
  input  wire logic                                  clk_i,
  input  wire logic                                  rst_i,
  input  wire logic                                  wb_cyc_i,
  input  wire logic                                  wb_stb_i,
  input  wire logic                                  wb_we_i,
  input  wire logic [link_status_pkg::ADR_W-1:0]     wb_adr_i,
  input  wire logic [31:0]                           wb_dat_i,
  input  wire logic [3:0]                            wb_sel_i,
  output logic      [31:0]                           wb_dat_o,
  output logic                                       wb_ack_o,
  output logic                                       irq_o,
  input  wire logic [link_status_pkg::UNIT_CNT-1:0]  unit_ok_i,
  input  wire logic                                  bcast_ok_i,
  input  wire logic                                  ctrl_link_ok_i,
  input  wire logic [link_status_pkg::BASE_W-1:0]    base_number_i,
  input  wire logic [link_status_pkg::SW_W-1:0]      address_range_switch_i
);
  import link_status_pkg::*;

  localparam int SYNC_W = UNIT_CNT + 2 + BASE_W + SW_W;

  logic [SYNC_W-1:0]       sync1_reg;
  logic [SYNC_W-1:0]       sync2_reg;
  logic [UNIT_CNT-1:0]     unit_s;
  logic                    bcast_s;
  logic                    ctrl_s;
  logic [BASE_W-1:0]       base_s;
  logic [SW_W-1:0]         address_range_switch;
  logic [WORD_W-1:0]       unit_link_next;
  logic [WORD_W-1:0]       unit_link_status_reg;
  logic [WORD_W-1:0]       base_link_status_reg;
  logic [WORD_W-1:0]       base_link_next;
  logic [FIRST_ADDR_W-1:0] first_addr_reg;
  logic [IRQ_W-1:0]        irq_stat_reg;
  logic [IRQ_W-1:0]        irq_mask_reg;
  logic [IRQ_W-1:0]        irq_event;
  logic [5:0]              word_idx;
  logic                    req;
  logic                    rd_req;
  logic                    wr_req;
  logic [31:0]             rd_next;

  // Two-flop synchroniser for all pins and switches
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {unit_ok_i, bcast_ok_i, ctrl_link_ok_i, base_number_i, address_range_switch_i};
      sync2_reg <= sync1_reg;
    end
  end

  assign {unit_s, bcast_s, ctrl_s, base_s, address_range_switch} = sync2_reg;

  // Unit k lands on bit number 17 - k; index k-1 is unit k
  for (genvar k = 1; k <= UNIT_CNT; k++) begin : g_unit
    assign unit_link_next[bit_idx(WORD_W + 1 - k)] = unit_s[k-1];   // [RULE_02] [RULE_03] [RULE_06]
  end
  assign unit_link_next[bit_idx(BCAST_BITNUM)] = bcast_s;         // [RULE_04] [RULE_06]

  // Controller link bit at bit number 16 - b, index b
  assign base_link_next = WORD_W'(ctrl_s) << base_s;              // [RULE_05] [RULE_06]

  // Latch status words and the first unit address of the range
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      unit_link_status_reg <= '0;
      base_link_status_reg <= '0;
      first_addr_reg       <= '0;
    end else begin
      unit_link_status_reg <= unit_link_next;
      base_link_status_reg <= base_link_next;
      first_addr_reg       <= FIRST_ADDR_W'(address_range_switch * UNIT_CNT);  // [RULE_03]
    end
  end

  // Bus request decode; answer one cycle after the request.
  // A write lands at the edge where the master sees ack, so a master that
  // abandons the cycle before that edge leaves the registers untouched.
  assign req      = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign rd_req   = req && !wb_we_i;
  assign wr_req   = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
  assign word_idx = wb_adr_i[ADR_W-1:2];

  // Changes in link words raise events
  assign irq_event[IRQ_UNIT] = unit_link_next != unit_link_status_reg;
  assign irq_event[IRQ_BASE] = base_link_next != base_link_status_reg;

  // Read mux; unmapped words read zero
  always_comb begin
    rd_next = '0;
    if (word_idx == 6'(base_s) + STW_OFFSET) begin
      rd_next[WORD_W-1:0] = unit_link_status_reg;               // [RULE_01]
    end else if (word_idx == STW_BASE_IDX) begin
      rd_next[WORD_W-1:0] = base_link_status_reg;               // [RULE_05]
    end else if (word_idx == INFO_IDX) begin
      rd_next = {20'h0, address_range_switch, first_addr_reg};
    end else if (word_idx == IRQ_STAT_IDX) begin
      rd_next[IRQ_W-1:0] = irq_stat_reg;
    end else if (word_idx == IRQ_MASK_IDX) begin
      rd_next[IRQ_W-1:0] = irq_mask_reg;
    end
  end

  // Acknowledge and read data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= rd_req ? rd_next : '0;
    end
  end

  // Sticky events, write one to clear; a new event wins over the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_reg <= '0;
    end else if (wr_req && word_idx == IRQ_STAT_IDX) begin
      irq_stat_reg <= (irq_stat_reg & ~wb_dat_i[IRQ_W-1:0]) | irq_event;
    end else begin
      irq_stat_reg <= irq_stat_reg | irq_event;
    end
  end

  // Mask register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_reg <= IRQ_MASK_RST;
    end else if (wr_req && word_idx == IRQ_MASK_IDX) begin
      irq_mask_reg <= wb_dat_i[IRQ_W-1:0];
    end
  end

  // Level interrupt
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // Checks on the mapping and the bus; all on the one clock, off during reset
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Read of the unit word selected by the base number
  sequence s_read_unit_word;
    rd_req && word_idx == 6'(base_s) + STW_OFFSET;
  endsequence

  // Ack carrying the unit word latched when the read was taken
  sequence s_unit_word_answer;
    wb_ack_o && wb_dat_o[WORD_W-1:0] == $past(unit_link_status_reg);
  endsequence

  // Read of the controller link word
  sequence s_read_base_word;
    rd_req && word_idx == STW_BASE_IDX;
  endsequence

  sequence s_base_word_answer;
    wb_ack_o && wb_dat_o[WORD_W-1:0] == $past(base_link_status_reg);
  endsequence

  // Accepted write to the event status word
  sequence s_stat_write;
    wr_req && word_idx == IRQ_STAT_IDX;
  endsequence

  sequence s_mask_write;
    wr_req && word_idx == IRQ_MASK_IDX;
  endsequence

  // Placement of the link bits in the words
  a_unit_word_read: assert property (s_read_unit_word |=> s_unit_word_answer)  // [RULE_01]
    else $error("unit word not at base plus 11");
  a_base_word_read: assert property (s_read_base_word |=> s_base_word_answer)  // [RULE_05]
    else $error("controller link word not returned");
  a_lsb_first_unit: assert property (##1 unit_link_status_reg[0] == $past(unit_s[0]))  // [RULE_02]
    else $error("unit 1 not on least significant bit");
  a_unit_fifteen: assert property (##1 unit_link_status_reg[WORD_W-2] == $past(unit_s[UNIT_CNT-1]))  // [RULE_03]
    else $error("unit 15 not on bit number 2");
  a_bcast_msb: assert property (##1 unit_link_status_reg[WORD_W-1] == $past(bcast_s))  // [RULE_04]
    else $error("broadcast channel not on msb");
  a_base_link_bit: assert property (  // [RULE_05]
      ##1 base_link_status_reg == (WORD_W'($past(ctrl_s)) << $past(base_s)))
    else $error("controller link bit misplaced");
  // First unit address of the range follows the switch
  a_first_addr: assert property (  // [RULE_03]
      ##1 first_addr_reg == FIRST_ADDR_W'($past(address_range_switch) * UNIT_CNT))
    else $error("first unit address is not switch times 15");
  a_ok_reads_one: assert property ((&unit_s && bcast_s) |=> unit_link_status_reg == '1)  // [RULE_06]
    else $error("good links do not read as ones");

  // Bus handshake
  a_ack_single: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single cycle pulse");
  a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == '0)
    else $error("read data not zero outside ack");

  // Events, mask and interrupt
  a_event_sets: assert property (##1 (irq_stat_reg & $past(irq_event)) == $past(irq_event))
    else $error("link change did not set its status bit");
  a_stat_sticky: assert property (!(wr_req && word_idx == IRQ_STAT_IDX) |=>
      (irq_stat_reg & $past(irq_stat_reg)) == $past(irq_stat_reg))
    else $error("status bit dropped without a clear");
  a_stat_clear: assert property (s_stat_write |=>
      (irq_stat_reg & $past(wb_dat_i[IRQ_W-1:0] & ~irq_event)) == '0)
    else $error("written one did not clear its status bit");
  a_mask_write: assert property (s_mask_write |=> irq_mask_reg == $past(wb_dat_i[IRQ_W-1:0]))
    else $error("mask write did not land");
  a_irq_level: assert property (##1 irq_o == |$past(irq_stat_reg & irq_mask_reg))
    else $error("interrupt does not follow masked status");
endmodule

/* dv/unit_link_model.sv */
// Remote units and controller link driving the status pins
`timescale 1ns/1ps
module unit_link_model (
  input  wire logic        clk_i,
  input  wire logic [16:0] pat_i,
  output logic      [14:0] unit_ok_o,
  output logic             bcast_ok_o,
  output logic             ctrl_ok_o
);
  // Link states follow the scenario one clock later, 1 = talking
  always_ff @(posedge clk_i) begin
    {ctrl_ok_o, bcast_ok_o, unit_ok_o} <= pat_i;
  end
endmodule

/* dv/test_unit_link_status_map.sv */
// Self-checking bench for the unit link status word map
`timescale 1ns/1ps
module test_unit_link_status_map;
  import link_status_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        we    = 1'b0;
  logic [7:0]  adr   = 8'h00;
  logic [31:0] dat   = 32'h0;
  logic [3:0]  sel   = 4'hf;
  logic [31:0] rdat, q;
  logic        ack, irq, bcast, ctrl;
  logic [14:0] units;
  logic [3:0]  base  = 4'h0;
  logic [3:0]  sw    = 4'h0;
  logic [16:0] pat   = 17'h0;
  int          fail_count = 0;
  int          cmp_count  = 0;

  unit_link_status_map i_unit_link_status_map (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
    .irq_o(irq), .unit_ok_i(units), .bcast_ok_i(bcast), .ctrl_link_ok_i(ctrl), .base_number_i(base),
    .address_range_switch_i(sw));
  unit_link_model i_unit_link_model (.clk_i(clk_i), .pat_i(pat), .unit_ok_o(units), .bcast_ok_o(bcast),
    .ctrl_ok_o(ctrl));

  initial begin
    forever #10 clk_i = ~clk_i;
  end

  task automatic report_and_stop;
    if (fail_count == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask

  // One classic cycle, held until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    if (n >= 50) begin
      fail_count++;
      report_and_stop();
    end
    cyc <= 1'b0;
  endtask

  task automatic reset_case;
    chk({31'h0, irq}, 32'h0);
    bus(1'b0, 8'h78, 32'h0);
    chk(q, {30'h0, IRQ_MASK_RST});
    bus(1'b0, 8'hfc, 32'h0);
    chk(q, 32'h0);
  endtask

  // Pins for base b, switch s, pattern {ctrl, bcast, units}
  task automatic map_case(input logic [3:0] b, input logic [3:0] s, input logic [16:0] p);
    base <= b;
    sw   <= s;
    pat  <= p;
    repeat (5) @(posedge clk_i);
    bus(1'b0, {6'(b) + STW_OFFSET, 2'b00}, 32'h0);
    chk(q, {16'h0, p[15], p[14:0]});
    bus(1'b0, {6'(b + 4'h1) + STW_OFFSET, 2'b00}, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, 8'h08, 32'h0);
    chk(q, 32'(p[16]) << b);
    bus(1'b0, 8'h70, 32'h0);
    chk(q, {20'h0, s, 8'(s) * 8'd15});
  endtask

  task automatic irq_case;
    bus(1'b1, 8'h74, 32'h3);
    pat <= 17'h0_1234;
    repeat (6) @(posedge clk_i);
    chk({31'h0, irq}, 32'h0);
    bus(1'b0, 8'h74, 32'h0);
    chk(q, 32'h3);
    sel <= 4'he;
    bus(1'b1, 8'h78, 32'h3);
    sel <= 4'hf;
    bus(1'b0, 8'h78, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, 8'h78, 32'h1);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, 8'h74, 32'h1);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq}, 32'h0);
    bus(1'b0, 8'h74, 32'h0);
    chk(q, 32'h2);
    bus(1'b1, 8'h08, 32'hffff);
    bus(1'b0, 8'h08, 32'h0);
    chk(q, 32'h0);
  endtask

  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    reset_case();
    map_case(4'h0, 4'h0, 17'h1_8001);
    map_case(4'h5, 4'h3, 17'h0_4aa5);
    map_case(4'hf, 4'hf, 17'h1_7ffe);
    map_case(4'ha, 4'h1, 17'h1_ffff);
    irq_case();
    report_and_stop();
  end
endmodule
